// ===== pkg/adc_seq_pkg.sv
// Summary of operation
// RULE_01 - Result is 10 bits, right aligned, left aligned when left adjust is one
// RULE_02 - Software reads low byte before high byte; left aligned 8-bit needs high only
// RULE_03 - Reading the low byte blocks result updates until the high byte is read
// RULE_04 - A conversion ending while blocked leaves both bytes unchanged; result lost
// RULE_05 - Reading the high byte re-enables result updates to both bytes
// RULE_06 - Complete flag is set at every conversion end, even a discarded one
// RULE_07 - Converter stays disabled while the power reduction bit is one
// RULE_08 - Writing start begins one conversion; bit stays one, hardware clears it at end
// RULE_09 - Channel change during a conversion applies only after that conversion ends
// RULE_10 - Reference and channel selections take effect only while enabled
// RULE_11 - Channel field selects eight pins, ground or the bandgap reference
// RULE_12 - Auto trigger enable starts conversions from the selected trigger source
// RULE_13 - Trigger rising edge resets the converter clock prescaler and starts conversion
// RULE_14 - Trigger held high at end starts nothing; edges during conversion are ignored
// RULE_15 - Trigger source flags act regardless of their interrupt enables
// RULE_16 - Software clears the trigger source flag before its next event can trigger
// RULE_17 - Own complete flag as trigger gives free running, restarting at each end
// RULE_18 - Software starts the first free running conversion with the start bit
// RULE_19 - Start bit still launches a single conversion while auto triggering
// RULE_20 - Start bit reads one during any conversion, however started
// RULE_21 - Normal conversion takes 13 converter clocks, first after enable 25
// RULE_22 - Prescaler counts while enabled and is held in reset while disabled
// RULE_23 - At completion result and flag update; single mode clears start same cycle
// RULE_24 - Trigger select code zero selects the own complete flag
// RULE_25 - Complete flag cleared by writing one or by interrupt acknowledge
package adc_seq_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int PS_W = 3;
  localparam int TSEL_W = 3;
  localparam int CH_W = 4;
  localparam int REF_W = 2;
  localparam int CNT_W = 5;
  localparam int TRIG_N = 8;
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_RESULT_LO = 3'h0;
  localparam logic [ADDR_W-1:0] REG_RESULT_HI = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CTRL_A = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL_B = 3'h3;
  localparam logic [ADDR_W-1:0] REG_INSEL = 3'h4;
  localparam logic [ADDR_W-1:0] REG_POWER = 3'h5;
  // Control A fields
  localparam int CA_EN = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  localparam int CA_PS_LSB = 0;
  // Control B, input select and power fields
  localparam int CB_TSEL_LSB = 0;
  localparam int IS_REF_LSB = 6;
  localparam int IS_LADJ = 5;
  localparam int IS_CH_LSB = 0;
  localparam int PW_PRR = 0;
  localparam logic PRR_RESET = 1'h0;
  // Conversion lengths in converter clocks
  localparam logic [CNT_W-1:0] LEN_NORMAL = 5'h0d;
  localparam logic [CNT_W-1:0] LEN_FIRST = 5'h19;
  // Trigger and channel codes
  localparam logic [TSEL_W-1:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [CH_W-1:0] CH_BANDGAP = 4'he;
  localparam logic [CH_W-1:0] CH_GROUND = 4'hf;
endpackage

// ===== core/conv_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic enable,
  input wire logic restart,
  input wire logic [adc_seq_pkg::PS_W-1:0] sel,
  // Converter clock enable
  output logic tick
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t q;
  div_state_t d;

  // Divide by two to the power sel plus one
  function automatic logic [W-1:0] div_limit(input logic [PS_W-1:0] s);
    logic [W:0] full;
    full = (W+1)'(2) << s;
    return W'(full - (W+1)'(1));
  endfunction

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!enable || restart) begin
      d.cnt = '0; // RULE_13 RULE_22
    end else if (q.cnt >= div_limit(sel)) begin
      // Greater-or-equal so a smaller divide setting never waits for a wrap
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  property p_held_when_off;
    @(posedge clock) disable iff (!nrst) !enable |=> !tick && q.cnt == '0;
  endproperty
  a_held_when_off: assert property (p_held_when_off) else $error("prescaler ran while off"); // RULE_22
endmodule
`default_nettype wire

// ===== core/adc_conversion_sequencer.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [adc_seq_pkg::ADDR_W-1:0] addr,
  input wire logic [adc_seq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [adc_seq_pkg::DATA_W-1:0] rdata,
  // Trigger sources and interrupt vector acknowledge
  input wire logic [adc_seq_pkg::TRIG_N-1:0] trigger_in,
  input wire logic irq_ack,
  output logic irq,
  // Analog core
  input wire logic [adc_seq_pkg::RES_W-1:0] sar_result,
  output logic analog_enable,
  output logic conv_active,
  output logic conv_done,
  output logic [adc_seq_pkg::CH_W-1:0] channel_active,
  output logic [adc_seq_pkg::REF_W-1:0] reference_active
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic en;
    logic start_req;
    logic auto_en;
    logic flag;
    logic ie;
    logic [PS_W-1:0] ps;
    logic [TSEL_W-1:0] tsel;
    logic [REF_W-1:0] ref_buf;
    logic ladj;
    logic [CH_W-1:0] ch_buf;
    logic pwr;
    logic busy;
    logic first;
    logic lock;
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] result;
    logic trig_prev;
    logic [REF_W-1:0] ref_act;
    logic [CH_W-1:0] ch_act;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic done;
    logic active;
    logic aen;
  } seq_state_t;

  seq_state_t q;
  seq_state_t d;
  logic tick;
  logic eff_en;
  logic free_run;
  logic trig_lvl;
  logic trig_edge;
  logic trig_start;
  logic done_now;
  logic [CNT_W-1:0] len;
  logic [2*DATA_W-1:0] aligned;

  // Both bytes of the result as software sees them
  function automatic logic [2*DATA_W-1:0] align(input logic [RES_W-1:0] r, input logic left);
    logic [2*DATA_W-1:0] v;
    if (left) begin
      v = {r, {(2*DATA_W-RES_W){1'b0}}}; // RULE_01
    end else begin
      v = {{(2*DATA_W-RES_W){1'b0}}, r}; // RULE_01
    end
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] read_reg(input logic [ADDR_W-1:0] a,
                                                  input seq_state_t s,
                                                  input logic [2*DATA_W-1:0] al);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case (a)
      REG_RESULT_LO: v = al[DATA_W-1:0];
      REG_RESULT_HI: v = al[2*DATA_W-1:DATA_W];
      REG_CTRL_A: begin
        v[CA_EN] = s.en;
        v[CA_START] = s.busy | s.start_req; // RULE_20
        v[CA_AUTO] = s.auto_en;
        v[CA_FLAG] = s.flag;
        v[CA_IE] = s.ie;
        v[CA_PS_LSB +: PS_W] = s.ps;
      end
      REG_CTRL_B: v[CB_TSEL_LSB +: TSEL_W] = s.tsel;
      REG_INSEL: begin
        v[IS_REF_LSB +: REF_W] = s.ref_buf;
        v[IS_LADJ] = s.ladj;
        v[IS_CH_LSB +: CH_W] = s.ch_buf;
      end
      REG_POWER: v[PW_PRR] = s.pwr;
      default: v = '0;
    endcase
    return v;
  endfunction

  conv_clock_divider #(
    .W(8)
  ) u_div (
    .clock(clock),
    .nrst(nrst),
    .enable(eff_en),
    .restart(trig_start),
    .sel(q.ps),
    .tick(tick)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    eff_en = q.en & ~q.pwr; // RULE_07
    aligned = align(q.result, q.ladj);
    free_run = q.auto_en && (q.tsel == TRIG_FREE_RUN); // RULE_24
    // Trigger level is used as is; source interrupt enables play no part
    trig_lvl = trigger_in[q.tsel]; // RULE_15
    trig_edge = trig_lvl & ~q.trig_prev;
    d.trig_prev = trig_lvl;
    trig_start = eff_en && q.auto_en && !free_run && trig_edge && !q.busy; // RULE_12 RULE_13 RULE_14
    len = q.first ? LEN_FIRST : LEN_NORMAL; // RULE_21
    done_now = q.busy && tick && (q.cnt + CNT_W'(1) == len);
    // Register writes
    if (wr) begin
      unique case (addr)
        REG_CTRL_A: begin
          d.en = wdata[CA_EN];
          d.auto_en = wdata[CA_AUTO];
          d.ie = wdata[CA_IE];
          d.ps = wdata[CA_PS_LSB +: PS_W];
          if (wdata[CA_FLAG]) begin
            d.flag = 1'b0; // RULE_25
          end
          if (wdata[CA_START] && wdata[CA_EN] && !q.pwr && !q.busy) begin
            d.start_req = 1'b1; // RULE_08 RULE_19
          end
        end
        REG_CTRL_B: d.tsel = wdata[CB_TSEL_LSB +: TSEL_W];
        REG_INSEL: begin
          d.ref_buf = wdata[IS_REF_LSB +: REF_W];
          d.ladj = wdata[IS_LADJ];
          d.ch_buf = wdata[IS_CH_LSB +: CH_W]; // RULE_11
        end
        REG_POWER: d.pwr = wdata[PW_PRR];
        default: d.pwr = q.pwr;
      endcase
    end
    if (irq_ack) begin
      d.flag = 1'b0; // RULE_25
    end
    // Result lock: low byte read blocks, high byte read releases
    if (rd && addr == REG_RESULT_LO) begin
      d.lock = 1'b1; // RULE_03
    end
    if (rd && addr == REG_RESULT_HI) begin
      d.lock = 1'b0; // RULE_05
    end
    d.rdata = rd ? read_reg(addr, q, aligned) : '0;
    // Conversion sequencing
    if (q.busy && tick) begin
      d.cnt = q.cnt + CNT_W'(1);
    end
    if (done_now) begin
      d.busy = 1'b0; // RULE_08 RULE_23
      d.first = 1'b0;
      d.done = 1'b1;
      d.flag = 1'b1; // RULE_06 RULE_23
      if (!q.lock) begin
        d.result = sar_result; // RULE_04 RULE_23
      end
      // Selection buffer is released in the last converter clock
      d.ch_act = q.ch_buf; // RULE_09
      d.ref_act = q.ref_buf;
      if (free_run) begin
        d.busy = 1'b1; // RULE_17
        d.cnt = '0;
      end
    end else if (trig_start) begin
      d.busy = 1'b1; // RULE_13
      d.cnt = '0;
      d.start_req = 1'b0;
    end else if (!q.busy && q.start_req && tick) begin
      // Software start waits for the next converter clock edge
      d.busy = 1'b1; // RULE_08 RULE_18
      d.cnt = '0;
      d.start_req = 1'b0;
    end
    if (eff_en && !q.busy) begin
      d.ch_act = q.ch_buf; // RULE_09 RULE_10
      d.ref_act = q.ref_buf; // RULE_10
    end
    if (!eff_en) begin
      d.busy = 1'b0; // RULE_07
      d.first = 1'b1; // RULE_21
      d.cnt = '0;
    end
    // A start written together with enable must survive until the first tick
    if (!d.en || d.pwr) begin
      d.start_req = 1'b0; // RULE_07
    end
    d.irq = d.flag & d.ie;
    d.active = d.busy;
    d.aen = eff_en;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.first <= 1'b1;
      q.pwr <= PRR_RESET;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq = q.irq;
  assign analog_enable = q.aen;
  assign conv_active = q.active;
  assign conv_done = q.done;
  assign channel_active = q.ch_act;
  assign reference_active = q.ref_act;

  property p_right_align;
    @(posedge clock) disable iff (!nrst)
      rd && addr == REG_RESULT_HI && !q.ladj |=> rdata == {6'h00, $past(q.result[9:8])};
  endproperty
  a_right_align: assert property (p_right_align) else $error("high byte misaligned"); // RULE_01

  property p_low_locks;
    @(posedge clock) disable iff (!nrst) rd && addr == REG_RESULT_LO |=> q.lock;
  endproperty
  a_low_locks: assert property (p_low_locks) else $error("low read did not lock"); // RULE_03

  property p_discard;
    @(posedge clock) disable iff (!nrst) done_now && q.lock |=> $stable(q.result);
  endproperty
  a_discard: assert property (p_discard) else $error("locked result overwritten"); // RULE_04

  property p_high_unlocks;
    @(posedge clock) disable iff (!nrst) rd && addr == REG_RESULT_HI |=> !q.lock;
  endproperty
  a_high_unlocks: assert property (p_high_unlocks) else $error("high read kept lock"); // RULE_05

  property p_flag_at_end;
    @(posedge clock) disable iff (!nrst) done_now |=> q.flag && conv_done;
  endproperty
  a_flag_at_end: assert property (p_flag_at_end) else $error("flag missed at end"); // RULE_06

  property p_power_off;
    @(posedge clock) disable iff (!nrst) q.pwr |=> !analog_enable && !conv_active;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter ran in power reduction"); // RULE_07

  property p_single_clears;
    @(posedge clock) disable iff (!nrst) done_now && !free_run |=> !conv_active;
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("start not cleared"); // RULE_08

  property p_chan_locked;
    @(posedge clock) disable iff (!nrst)
      q.busy && $past(q.busy) && !q.done |-> $stable(q.ch_act);
  endproperty
  a_chan_locked: assert property (p_chan_locked) else $error("channel changed mid conversion"); // RULE_09

  property p_edge_ignored;
    @(posedge clock) disable iff (!nrst)
      q.busy && trig_edge && !tick && !done_now |=> q.cnt == $past(q.cnt);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("busy edge restarted"); // RULE_14

  property p_free_run;
    @(posedge clock) disable iff (!nrst) done_now && free_run && eff_en |=> q.busy [*2];
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running stopped"); // RULE_17

  c_lost_result: cover property (@(posedge clock) disable iff (!nrst) done_now && q.lock);
  c_trig_start: cover property (@(posedge clock) disable iff (!nrst) trig_start);
  c_free_run: cover property (@(posedge clock) disable iff (!nrst) done_now && free_run);
endmodule
`default_nettype wire

// ===== verif/sar_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Sequencer side
  input wire logic conv_active,
  input wire logic conv_done,
  input wire logic [adc_seq_pkg::CH_W-1:0] channel_active,
  output logic [adc_seq_pkg::RES_W-1:0] sar_result
);
  logic [5:0] n_q;
  // Idle output flips every cycle so a stale capture cannot match by chance
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      n_q <= 6'h00;
      sar_result <= 10'h155;
    end else begin
      if (conv_done) n_q <= n_q + 6'h01;
      sar_result <= conv_active ? {channel_active, n_q} : ~sar_result;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_seq_pkg::*;
  logic clock, nrst, wr, rd, irq_ack, irq, analog_enable, conv_active, conv_done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [TRIG_N-1:0] trigger_in;
  logic [RES_W-1:0] sar_result;
  logic [CH_W-1:0] channel_active;
  logic [REF_W-1:0] reference_active;
  int mismatches, checks_done, ndone, alen, elen, lock, la, ch_sw, ch_run, res, seed, pa;
  int c, ps, t;
  adc_conversion_sequencer i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .trigger_in(trigger_in), .irq_ack(irq_ack), .irq(irq),
    .sar_result(sar_result), .analog_enable(analog_enable), .conv_active(conv_active),
    .conv_done(conv_done), .channel_active(channel_active),
    .reference_active(reference_active));
  sar_core_model i_sar (.clock(clock), .nrst(nrst), .conv_active(conv_active),
    .conv_done(conv_done), .channel_active(channel_active), .sar_result(sar_result));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] al(input int r);
    return la ? {r[9:0], 6'h00} : {6'h00, r[9:0]};
  endfunction
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    if (a == REG_RESULT_LO) lock = 1;
    if (a == REG_RESULT_HI) lock = 0;
    #1;
    chk_pin(rdata, e);
  endtask
  task automatic chk_res();
    logic [15:0] e;
    e = al(res);
    chk_rd(REG_RESULT_LO, e[7:0]);
    chk_rd(REG_RESULT_HI, e[15:8]);
  endtask
  task automatic wait_conv(input int n);
    int t0;
    t0 = ndone + n;
    for (int k = 0; k < 4000 && ndone < t0; k++) @(negedge clock);
    chk_pin(ndone, t0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reference model: channel latched at start, result held while the bytes are locked
  always @(negedge clock) begin
    if (conv_active && pa == 0) ch_run = ch_sw;
    if (conv_active) chk_pin(channel_active, ch_run);
    if (conv_active) alen++;
    if (conv_done) begin
      if (elen != 0) chk_pin(alen, elen);
      alen = 0;
      if (lock == 0) res = {ch_run[3:0], ndone[5:0]};
      ndone++;
    end
    pa = conv_active;
  end
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {nrst, wr, rd, irq_ack, addr, wdata, trigger_in} = '0;
    {ndone, alen, elen, lock, la, res, pa, ch_run} = '0;
    seed = 77205;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    wr_reg(3'h6, 8'hff);
    chk_rd(3'h6, 8'h00);
    chk_rd(REG_CTRL_A, 8'h00);
    ch_sw = 3;
    wr_reg(REG_INSEL, 8'h83);
    wr_reg(REG_POWER, 8'h01);
    wr_reg(REG_CTRL_A, 8'hc8);
    repeat (4) @(negedge clock);
    chk_pin({analog_enable, conv_active}, 0);
    wr_reg(REG_CTRL_A, 8'h00);
    wr_reg(REG_POWER, 8'h00);
    @(negedge clock);
    chk_pin(reference_active, 0);
    elen = LEN_FIRST * 2;
    wr_reg(REG_CTRL_A, 8'hc8);
    chk_rd(REG_CTRL_A, 8'hc8);
    chk_pin(reference_active, 2);
    wr_reg(REG_INSEL, 8'h85);
    ch_sw = 5;
    wait_conv(1);
    chk_rd(REG_CTRL_A, 8'h98);
    chk_pin(irq, 1);
    chk_res();
    wr_reg(REG_CTRL_A, 8'h98);
    chk_rd(REG_CTRL_A, 8'h88);
    // Random channel, alignment and prescale; codes 8 and 9 map to bandgap and ground
    for (int i = 0; i < 8; i++) begin
      c = (xs() & 32'h7fffffff) % 10;
      ch_sw = (c == 8) ? CH_BANDGAP : (c == 9) ? CH_GROUND : c;
      la = xs() & 1;
      ps = xs() & 3;
      wr_reg(REG_INSEL, {2'h1, la[0], 1'b0, ch_sw[3:0]});
      elen = LEN_NORMAL * (2 << ps);
      wr_reg(REG_CTRL_A, {5'h1a, ps[2:0]});
      wait_conv(1);
      chk_res();
    end
    chk_rd(REG_RESULT_LO, al(res) & 16'h00ff);
    elen = LEN_NORMAL * 2;
    wr_reg(REG_CTRL_A, 8'hd0);
    wait_conv(1);
    chk_rd(REG_CTRL_A, 8'h90);
    chk_rd(REG_RESULT_HI, al(res) >> 8);
    wr_reg(REG_CTRL_A, 8'hd0);
    wait_conv(1);
    chk_res();
    elen = 0;
    for (int k = 1; k < TRIG_N; k++) begin
      wr_reg(REG_CTRL_B, 8'(k));
      wr_reg(REG_CTRL_A, 8'hb0);
      t = ndone;
      trigger_in <= TRIG_N'(1) << k;
      chk_rd(REG_CTRL_A, 8'he0);
      trigger_in <= '0;
      @(posedge clock);
      trigger_in <= TRIG_N'(1) << k;
      wait_conv(1);
      repeat (60) @(posedge clock);
      chk_pin(ndone, t + 1);
      trigger_in <= '0;
    end
    wr_reg(REG_CTRL_A, 8'he0);
    wait_conv(1);
    wr_reg(REG_CTRL_B, 8'(TRIG_FREE_RUN));
    wr_reg(REG_CTRL_A, 8'hf0);
    wait_conv(3);
    chk_rd(REG_CTRL_A, 8'hf0);
    wr_reg(REG_CTRL_A, 8'h90);
    wait_conv(1);
    t = ndone;
    repeat (60) @(posedge clock);
    chk_pin(ndone, t);
    chk_res();
    wr_reg(REG_CTRL_A, 8'h88);
    repeat (2) @(negedge clock);
    chk_pin(irq, 1);
    @(posedge clock);
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
    chk_rd(REG_CTRL_A, 8'h88);
    chk_pin(irq, 0);
    wr_reg(REG_CTRL_A, 8'h00);
    repeat (2) @(negedge clock);
    chk_pin(analog_enable, 0);
    elen = LEN_FIRST * 2;
    wr_reg(REG_CTRL_A, 8'hd0);
    wait_conv(1);
    chk_res();
    tally_and_finish();
  end
endmodule
`default_nettype wire
